/* File: rtl/stop_cmd_pkg.sv */
// package: constants and carrier structs for the stop position command handshake
package stop_cmd_pkg;
	localparam int          WORD_W          = 16;
	localparam int          POS_W           = 32;
	localparam int          WIDX_W          = 3;
	localparam logic [2:0]  TGT_LOW_IDX     = 3'h4;
	localparam logic [2:0]  TGT_HIGH_IDX    = 3'h5;
	localparam logic [2:0]  POS_LOW_IDX     = 3'h6;
	localparam logic [2:0]  POS_HIGH_IDX    = 3'h7;
	localparam int          STATION_WORDS   = 4;
	localparam int          BIT_BLOCK       = 32;
	localparam logic [31:0] TARGET_RESET    = 32'h0000_0000;
	localparam int          JUDGE_CYCLES    = 2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_JUDGE = 2'b01,
		ST_DONE  = 2'b10
	} hs_state_e;

	// command words written by the master
	typedef struct packed {
		logic [15:0] target_low_command_word;
		logic [15:0] target_high_command_word;
		logic        target_write_request;
	} cmd_s;

	// status bits back to the master
	typedef struct packed {
		logic target_receipt_done;
		logic target_rejected;
		logic position_feed_active;
		logic speed_feed_active;
		logic fork_control_active;
		logic system_failure_flag;
	} status_s;

	// drive state feeding judgement
	typedef struct packed {
		logic [31:0] position;
		logic [31:0] lower_limit;
		logic [31:0] upper_limit;
		logic [31:0] stop_distance;
		logic        running;
		logic        forward;
		logic        decelerating;
	} drive_s;
endpackage

/* File: rtl/stop_position_cmd_handshake.sv */
// module: device-side stop position command handshake and status bits
// How it works
// - master loads both words, then raises request; device copies value for judging.
// - target is signed 32-bit, 0.1 mm steps, low half low word.
// - while request high, judge then raise receipt-done, accepted or refused.
// - receipt-done drops after the master drops the request.
// - at receipt, rejected flag low when accepted, high when refused.
// - rejected flag drops after the master drops the request.
// - refuse targets below lower limit or above upper limit.
// - refuse targets arriving while the drive decelerates.
// - while running, refuse targets already passed or too close to stop.
// - on refusal keep the previously accepted target.
// - position-feed flag follows position feed mode selection.
// - speed-feed flag follows speed feed mode selection.
// - fork-control flag follows fork control selection.
// - system-failure flag rises on detected failure.
// - failure flag holds until failure cleared then drive reset.
// - target low half in command word four, high in word five.
// - reply words four/five accepted target, six/seven current position.
// - exchange spans two stations; command words six, seven are free.
// - word base index derives from the station number (station times four); no bit base is derived.
`timescale 1ns/1ps
`default_nettype none
module stop_position_cmd_handshake #(
	parameter int STATIONS = 64
) (
	input  wire logic                    clock_i,
	input  wire logic                    reset_n_i,
	input  wire logic [7:0]              station_no_i,
	input  wire logic                    cmd_word_we_i,
	input  wire logic [8:0]              cmd_word_addr_i,
	input  wire logic [15:0]             cmd_word_data_i,
	input  wire logic                    request_bit_i,
	input  wire logic [8:0]              reply_word_addr_i,
	input  wire stop_cmd_pkg::drive_s    drive_i,
	input  wire logic                    mode_position_i,
	input  wire logic                    mode_speed_i,
	input  wire logic                    mode_fork_i,
	input  wire logic                    failure_detect_i,
	input  wire logic                    failure_cleared_i,
	input  wire logic                    drive_reset_i,
	output logic [15:0]                  reply_word_o,
	output stop_cmd_pkg::status_s        status_o,
	output logic [31:0]                  accepted_target_o
);
	import stop_cmd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		hs_state_e   state;
		cmd_s        cmd;
		logic [31:0] work;
		logic [31:0] target;
		status_s     status;
		logic        fail_cleared;
		logic        req_m;
		logic        req_s;
		logic [15:0] reply;
		logic [8:0]  base;
	} top_s;

	top_s        st_q;
	top_s        st_d;
	logic        judge_start;
	logic        judge_done;
	logic        judge_refuse;
	logic [8:0]  rel_addr;
	logic [8:0]  rel_reply;
	logic        in_block;
	logic        reply_in_block;

	////////////////////////////////////////////////////////////////////////////
	// judgement

	stop_target_judge u_judge (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.start_i   (judge_start),
		.cand_i    (st_q.work),
		.drive_i   (drive_i),
		.done_o    (judge_done),
		.refuse_o  (judge_refuse)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_d        = st_q;
		judge_start = 1'b0;
		// word block of this station pair starts at station number times words
		st_d.base   = 9'(station_no_i) * 9'(STATION_WORDS);
		rel_addr    = cmd_word_addr_i - st_q.base;
		rel_reply   = reply_word_addr_i - st_q.base;
		in_block    = cmd_word_addr_i >= st_q.base && rel_addr < 9'h008;
		reply_in_block = reply_word_addr_i >= st_q.base && rel_reply < 9'h008;
		st_d.req_m  = request_bit_i;
		st_d.req_s  = st_q.req_m;

		if (cmd_word_we_i && in_block) begin
			unique case (rel_addr[2:0])
				TGT_LOW_IDX:  st_d.cmd.target_low_command_word  = cmd_word_data_i;
				TGT_HIGH_IDX: st_d.cmd.target_high_command_word = cmd_word_data_i;
				default: ;
			endcase
		end
		st_d.cmd.target_write_request = st_q.req_s;

		unique case (st_q.state)
			ST_IDLE: begin
				if (st_q.req_s) begin
					// copy both halves into working memory for judging
					st_d.work  = {st_q.cmd.target_high_command_word,
						st_q.cmd.target_low_command_word};
					st_d.state = ST_JUDGE;
				end
			end
			ST_JUDGE: begin
				if (judge_done) begin
					if (!judge_refuse) begin
						st_d.target = st_q.work;
					end
					st_d.status.target_receipt_done = 1'b1;
					st_d.status.target_rejected     = judge_refuse;
					st_d.state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (!st_q.req_s) begin
					st_d.status.target_receipt_done = 1'b0;
					st_d.status.target_rejected     = 1'b0;
					st_d.state = ST_IDLE;
				end
			end
			default: st_d.state = ST_IDLE;
		endcase
		// one start pulse on entry to judging, failure state plays no part
		judge_start = (st_q.state == ST_JUDGE) && !judge_done &&
			st_q.cmd.target_write_request;

		st_d.status.position_feed_active = mode_position_i;
		st_d.status.speed_feed_active    = mode_speed_i;
		st_d.status.fork_control_active  = mode_fork_i;

		if (failure_detect_i) begin
			st_d.status.system_failure_flag = 1'b1;
			st_d.fail_cleared = 1'b0;
		end else if (st_q.status.system_failure_flag) begin
			if (failure_cleared_i) begin
				st_d.fail_cleared = 1'b1;
			end
			if (st_q.fail_cleared && drive_reset_i) begin
				st_d.status.system_failure_flag = 1'b0;
				st_d.fail_cleared = 1'b0;
			end
		end

		st_d.reply = 16'h0000;
		if (reply_in_block) begin
			unique case (rel_reply[2:0])
				TGT_LOW_IDX:  st_d.reply = st_q.target[15:0];
				TGT_HIGH_IDX: st_d.reply = st_q.target[31:16];
				POS_LOW_IDX:  st_d.reply = drive_i.position[15:0];
				POS_HIGH_IDX: st_d.reply = drive_i.position[31:16];
				default:      st_d.reply = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			st_q        <= '0;
			st_q.state  <= ST_IDLE;
			st_q.target <= TARGET_RESET;
			st_q.work   <= TARGET_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign reply_word_o      = st_q.reply;
	assign status_o          = st_q.status;
	assign accepted_target_o = st_q.target;

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_done_needs_req: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		$rose(status_o.target_receipt_done) |-> $past(st_q.req_s, 1))
		else $error("done without request");

	a_done_drops: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		status_o.target_receipt_done && !st_q.req_s |=> !status_o.target_receipt_done)
		else $error("done stuck");

	a_rej_only_done: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		status_o.target_rejected |-> status_o.target_receipt_done)
		else $error("rejected alone");

	a_reject_keeps: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		$rose(status_o.target_rejected) |-> $stable(accepted_target_o))
		else $error("target changed");

	a_accept_loads: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		$rose(status_o.target_receipt_done) && !status_o.target_rejected
		|-> accepted_target_o == st_q.work)
		else $error("target not loaded");

	a_mode_follow: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_position_i |=> status_o.position_feed_active)
		else $error("position feed flag");

	a_speed_follow: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_speed_i |=> status_o.speed_feed_active)
		else $error("speed feed flag");

	a_fork_follow: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_fork_i |=> status_o.fork_control_active)
		else $error("fork control flag");

	a_fail_set: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		failure_detect_i |=> status_o.system_failure_flag)
		else $error("failure not flagged");

	a_fail_hold: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		$fell(status_o.system_failure_flag) |-> $past(drive_reset_i, 1))
		else $error("failure dropped early");

	a_fail_clear_first: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		$fell(status_o.system_failure_flag) |-> $past(st_q.fail_cleared, 1))
		else $error("failure dropped before clear");

	a_fail_keep: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		status_o.system_failure_flag && !drive_reset_i |=> status_o.system_failure_flag)
		else $error("failure flag lost");

	a_rej_drops: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		status_o.target_rejected && !st_q.req_s |=> !status_o.target_rejected)
		else $error("rejected stuck");

	a_done_timely: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		st_q.state == ST_JUDGE |-> ##[1:2] status_o.target_receipt_done)
		else $error("judgement too slow");

	a_work_copy: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		st_q.state == ST_IDLE && st_q.req_s |=> st_q.work ==
			$past({st_q.cmd.target_high_command_word, st_q.cmd.target_low_command_word}))
		else $error("working copy wrong");

	a_refuse_high: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		judge_start && $signed(st_q.work) > $signed(drive_i.upper_limit) |=> judge_refuse)
		else $error("above upper limit taken");

	a_refuse_low: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		judge_start && $signed(st_q.work) < $signed(drive_i.lower_limit) |=> judge_refuse)
		else $error("below lower limit taken");

	a_cmd_low: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		cmd_word_we_i && in_block && rel_addr[2:0] == TGT_LOW_IDX
		|=> st_q.cmd.target_low_command_word == $past(cmd_word_data_i))
		else $error("low command word not stored");

	a_cmd_high: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		cmd_word_we_i && in_block && rel_addr[2:0] == TGT_HIGH_IDX
		|=> st_q.cmd.target_high_command_word == $past(cmd_word_data_i))
		else $error("high command word not stored");

	a_cmd_free: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		cmd_word_we_i && !(in_block && (rel_addr[2:0] == TGT_LOW_IDX ||
			rel_addr[2:0] == TGT_HIGH_IDX))
		|=> $stable({st_q.cmd.target_high_command_word, st_q.cmd.target_low_command_word}))
		else $error("free word changed target");

	a_base_calc: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		1'b1 |=> st_q.base == 9'(STATION_WORDS) * 9'($past(station_no_i)))
		else $error("word base wrong");

	a_reply_tgt_low: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		reply_in_block && rel_reply[2:0] == TGT_LOW_IDX
		|=> reply_word_o == $past(accepted_target_o[15:0]))
		else $error("reply target low");

	a_reply_tgt_high: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		reply_in_block && rel_reply[2:0] == TGT_HIGH_IDX
		|=> reply_word_o == $past(accepted_target_o[31:16]))
		else $error("reply target high");

	a_reply_pos_low: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		reply_in_block && rel_reply[2:0] == POS_LOW_IDX
		|=> reply_word_o == $past(drive_i.position[15:0]))
		else $error("reply position low");

	a_reply_pos_high: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		reply_in_block && rel_reply[2:0] == POS_HIGH_IDX
		|=> reply_word_o == $past(drive_i.position[31:16]))
		else $error("reply position high");
endmodule
`default_nettype wire

/* File: rtl/stop_target_judge.sv */
// module: range and reachability judgement of a candidate stop target
`timescale 1ns/1ps
`default_nettype none
module stop_target_judge (
	input  wire logic                   clock_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   start_i,
	input  wire logic [31:0]            cand_i,
	input  wire stop_cmd_pkg::drive_s   drive_i,
	output logic                        done_o,
	output logic                        refuse_o
);
	import stop_cmd_pkg::*;

	typedef struct packed {
		logic done;
		logic refuse;
	} judge_s;

	judge_s      st_q;
	judge_s      st_d;
	logic signed [32:0] reach;
	logic        out_range;
	logic        unreachable;

	always_comb begin
		out_range = ($signed(cand_i) < $signed(drive_i.lower_limit)) ||
			($signed(cand_i) > $signed(drive_i.upper_limit));
		reach = drive_i.forward ?
			($signed({drive_i.position[31], drive_i.position}) +
				$signed({1'b0, drive_i.stop_distance})) :
			($signed({drive_i.position[31], drive_i.position}) -
				$signed({1'b0, drive_i.stop_distance}));
		unreachable = drive_i.running && (drive_i.forward ?
			($signed({cand_i[31], cand_i}) < reach) :
			($signed({cand_i[31], cand_i}) > reach));
		st_d.done   = start_i;
		st_d.refuse = st_q.refuse;
		if (start_i) begin
			st_d.refuse = out_range || drive_i.decelerating || unreachable;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done_o   = st_q.done;
	assign refuse_o = st_q.refuse;

	a_judge_decel: assert property (
		@(posedge clock_i) disable iff (!reset_n_i)
		start_i && drive_i.decelerating |=> done_o && refuse_o)
		else $error("decel not refused");
endmodule
`default_nettype wire

/* File: sim/net_master.sv */
// partner model: network master that writes stop targets
`timescale 1ns/1ps
`default_nettype none
module net_master (
	input  wire logic                  clock_i,
	input  wire logic [7:0]            station_no_i,
	input  wire stop_cmd_pkg::status_s status_i,
	output logic                       we_o,
	output logic [8:0]                 addr_o,
	output logic [15:0]                data_o,
	output logic                       req_o
);
	import stop_cmd_pkg::*;
	initial begin
		we_o <= 1'b0;
		addr_o <= 9'h000;
		data_o <= 16'h0000;
		req_o <= 1'b0;
	end
	// one word write; released lines show the inverse
	task automatic put(input logic [2:0] rel, input logic [15:0] d);
		@(posedge clock_i);
		we_o <= 1'b1;
		addr_o <= 9'(station_no_i * 4 + rel);
		data_o <= d;
		@(posedge clock_i);
		we_o <= 1'b0;
		addr_o <= ~addr_o;
		data_o <= ~d;
	endtask
	// request, wait receipt, read verdict, release
	task automatic ask(output logic rej, output logic ok);
		int n;
		@(posedge clock_i);
		req_o <= 1'b1;
		n = 0;
		while (status_i.target_receipt_done !== 1'b1 && n < 40) begin
			@(posedge clock_i);
			n++;
		end
		ok = (n < 40);
		rej = status_i.target_rejected;
		req_o <= 1'b0;
		n = 0;
		while (status_i.target_receipt_done !== 1'b0 && n < 40) begin
			@(posedge clock_i);
			n++;
		end
		ok = ok && (n < 40);
	endtask
	task automatic send(input logic [31:0] t, output logic rej, output logic ok);
		put(3'h4, t[15:0]);
		put(3'h5, t[31:16]);
		ask(rej, ok);
	endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: stop target handshake, flags and reply words
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import stop_cmd_pkg::*;
	typedef struct packed {
		logic [31:0] tgt;
		logic [31:0] pos;
		logic        run;
		logic        fwd;
		logic        dec;
		logic        rej;
	} row_s;
	logic        clock_i, reset_n_i, we, req, rej, ok;
	logic [7:0]  station;
	logic [8:0]  addr, raddr;
	logic [15:0] data, reply_word_o;
	logic [2:0]  mode, fail_v;
	logic [31:0] acc, accepted_target_o;
	drive_s      drive;
	status_s     status_o;
	int          errors, cmp_count;
	// limits -1000..1000, stop distance 50
	row_s rows[11] = '{
		{32'h0000_0064, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0},
		{32'h0000_03e9, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b1},
		{32'hffff_fc18, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0},
		{32'hffff_fc17, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b1},
		{32'h0000_03e8, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0},
		{32'h0000_00c8, 32'h0000_0000, 1'b1, 1'b1, 1'b1, 1'b1},
		{32'h0000_001e, 32'h0000_0000, 1'b1, 1'b1, 1'b0, 1'b1},
		{32'hffff_fff6, 32'h0000_0000, 1'b1, 1'b1, 1'b0, 1'b1},
		{32'h0000_0032, 32'h0000_0000, 1'b1, 1'b1, 1'b0, 1'b0},
		{32'hffff_ffd8, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 1'b1},
		{32'hffff_ffc4, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 1'b0}
	};
	net_master m (.clock_i(clock_i), .station_no_i(station), .status_i(status_o),
		.we_o(we), .addr_o(addr), .data_o(data), .req_o(req));
	stop_position_cmd_handshake DUT (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.station_no_i(station), .cmd_word_we_i(we), .cmd_word_addr_i(addr),
		.cmd_word_data_i(data), .request_bit_i(req), .reply_word_addr_i(raddr),
		.drive_i(drive), .mode_position_i(mode[2]), .mode_speed_i(mode[1]),
		.mode_fork_i(mode[0]), .failure_detect_i(fail_v[2]),
		.failure_cleared_i(fail_v[1]), .drive_reset_i(fail_v[0]),
		.reply_word_o(reply_word_o), .status_o(status_o),
		.accepted_target_o(accepted_target_o));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic rd(input logic [2:0] rel, input logic [15:0] exp);
		@(posedge clock_i);
		raddr <= 9'(station * 4 + rel);
		repeat (2) @(posedge clock_i);
		check(32'(reply_word_o), 32'(exp));
	endtask
	task automatic fpulse(input logic [2:0] v, input logic exp);
		@(posedge clock_i);
		fail_v <= v;
		@(posedge clock_i);
		fail_v <= 3'h0;
		repeat (2) @(posedge clock_i);
		check(32'(status_o.system_failure_flag), 32'(exp));
	endtask
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		errors++;
		stop_test();
	end
	initial begin
		reset_n_i = 1'b0;
		station = 8'h03;
		raddr = 9'h000;
		mode = 3'h0;
		fail_v = 3'h0;
		drive = {32'h0000_0000, 32'hffff_fc18, 32'h0000_03e8, 32'h0000_0032, 1'b0, 1'b0, 1'b0};
		acc = 32'h0;
		errors = 0;
		cmp_count = 0;
		repeat (8) @(posedge clock_i);
		reset_n_i <= 1'b1;
		@(posedge clock_i);
		check(32'(status_o), 32'h0);
		for (int i = 0; i < 11; i++) begin
			@(posedge clock_i);
			drive.position <= rows[i].pos;
			drive.running <= rows[i].run;
			drive.forward <= rows[i].fwd;
			drive.decelerating <= rows[i].dec;
			if (!rows[i].rej) acc = rows[i].tgt;
			m.send(rows[i].tgt, rej, ok);
			check(32'(ok), 32'h1);
			check(32'(rej), 32'(rows[i].rej));
			check(32'(status_o.target_rejected), 32'h0);
			check(accepted_target_o, acc);
		end
		drive.position <= 32'h1234_5678;
		rd(3'h4, acc[15:0]);
		rd(3'h5, acc[31:16]);
		rd(3'h6, 16'h5678);
		rd(3'h7, 16'h1234);
		m.put(3'h6, 16'h00ff);
		m.put(3'h7, 16'h00ff);
		m.ask(rej, ok);
		check(32'(ok), 32'h1);
		check(32'(rej), 32'h0);
		check(accepted_target_o, acc);
		station <= 8'h05;
		drive.running <= 1'b0;
		m.send(32'h0000_0123, rej, ok);
		check(accepted_target_o, 32'h0000_0123);
		rd(3'h4, 16'h0123);
		for (int k = 0; k < 3; k++) begin
			@(posedge clock_i);
			mode <= 3'b100 >> k;
			repeat (2) @(posedge clock_i);
			check(32'(status_o[3:1]), 32'(3'b100 >> k));
		end
		fpulse(3'b100, 1'b1);
		fpulse(3'b001, 1'b1);
		fpulse(3'b010, 1'b1);
		fpulse(3'b001, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
